// [src/nalu_pkg.sv]
// Package with opcodes, register addresses and constants of the nibble ALU.
`default_nettype none
package nalu_pkg;

  localparam int unsigned NIB_W = 4;
  localparam int unsigned SYS_ADDR_W = 7;

  // Program status word system register addresses.
  localparam logic [6:0] PSW_LOW_ADDR  = 7'h7E;
  localparam logic [6:0] PSW_HIGH_ADDR = 7'h7F;

  // Field positions inside the two status nibbles.
  localparam int unsigned PSW_LO_INDEX_BIT   = 0;
  localparam int unsigned PSW_LO_DECIMAL_BIT = 1;
  localparam int unsigned PSW_HI_ZERO_BIT    = 0;
  localparam int unsigned PSW_HI_CARRY_BIT   = 1;
  localparam int unsigned PSW_HI_COMPARE_BIT = 2;

  localparam logic [3:0] NIB_ZERO   = 4'h0;
  localparam logic [3:0] NIB_TEN    = 4'hA;
  localparam logic [3:0] NIB_SIX    = 4'h6;
  localparam logic [4:0] SUM_TWENTY = 5'h14;
  localparam logic [3:0] BCD_ADJ    = 4'h6;
  localparam logic [4:0] SUM_TWENTY_EIGHT = 5'h1C;
  localparam logic [3:0] NIB_TWO          = 4'h2;

  typedef enum logic [4:0] {
    NALU_OP_ADD,
    NALU_OP_ADD_WITH_CARRY,
    NALU_OP_SUB,
    NALU_OP_SUBTRACT_WITH_BORROW,
    NALU_OP_AND,
    NALU_OP_OR,
    NALU_OP_XOR,
    NALU_OP_SKIP_IF_BITS_SET,
    NALU_OP_SKIP_IF_BITS_CLEAR,
    NALU_OP_SKIP_IF_EQUAL,
    NALU_OP_SKIP_IF_UNEQUAL,
    NALU_OP_SKIP_IF_NO_BORROW,
    NALU_OP_SKIP_IF_BORROW,
    NALU_OP_ROTATE_RIGHT_THROUGH_CARRY,
    NALU_OP_NONE
  } nalu_op_e;

endpackage : nalu_pkg
`default_nettype wire

// [src/nalu_decimal_fix.sv]
// Decimal correction of a 4-bit sum or difference.
`timescale 1ns/1ns
`default_nettype none
module nalu_decimal_fix (
  input  wire logic [4:0] raw_in,
  input  wire logic       subtract_in,
  output logic      [3:0] fixed_out,
  output logic            carry_out
);
  import nalu_pkg::*;

  logic [3:0] low_nib;
  logic       raw_carry;
  logic       add_adjust;
  logic [3:0] table_value;
  logic [3:0] add_value;
  logic [3:0] sub_value;

  assign low_nib   = raw_in[3:0];
  assign raw_carry = raw_in[4];

  // Ten and more, or a carry or borrow, leave the digit range.
  assign add_adjust  = raw_carry || (low_nib >= NIB_TEN);
  // Out-of-range codes keep bit zero, invert bit one and force 11xx.
  assign table_value = {2'b11, ~low_nib[1], low_nib[0]};
  // Sums of twenty-eight and more fall back by two instead.
  assign add_value   = (raw_in >= SUM_TWENTY_EIGHT) ? low_nib - NIB_TWO
                     : (raw_in >= SUM_TWENTY) ? table_value
                     : low_nib + BCD_ADJ;
  // Borrows down to minus ten wrap by six; anything else takes the table.
  assign sub_value   = (raw_carry && low_nib >= NIB_SIX) ? low_nib - BCD_ADJ
                     : table_value;

  assign fixed_out = !add_adjust ? low_nib
                   : subtract_in ? sub_value
                   : add_value;
  // A difference of ten to fifteen is no digit either and reports a borrow.
  assign carry_out = add_adjust;
endmodule : nalu_decimal_fix
`default_nettype wire

// [src/nalu_core.sv]
// Nibble ALU with temporary registers and status flip-flops.
`timescale 1ns/1ns
`default_nettype none
module nalu_core (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              start_in,
  input  wire nalu_pkg::nalu_op_e op_in,
  input  wire logic        [3:0] first_operand_in,
  input  wire logic        [3:0] second_operand_in,
  input  wire logic              next_is_instr_in,
  input  wire logic              sys_write_in,
  input  wire logic        [6:0] sys_addr_in,
  input  wire logic        [3:0] sys_wdata_in,
  input  wire logic        [6:0] sys_raddr_in,
  output logic             [3:0] sys_rdata_out,
  output logic             [3:0] result_out,
  output logic                   result_valid_out,
  output logic                   write_back_out,
  output logic                   skip_out,
  output logic                   squash_out,
  output logic                   index_modify_out,
  output logic                   zero_flag_out,
  output logic                   carry_flag_out,
  output logic                   compare_mode_flag_out,
  output logic                   decimal_mode_flag_out
);
  import nalu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] temp_a;
  logic [3:0] temp_b;
  nalu_op_e   held_op;
  logic       compute;
  logic       zero_flag;
  logic       carry_flag;
  logic       compare_mode_flag;
  logic       decimal_mode_flag;
  logic       index_enable_flag;
  logic       skip_pending;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire is_add   = held_op == NALU_OP_ADD ||
                  held_op == NALU_OP_ADD_WITH_CARRY;
  wire is_sub   = held_op == NALU_OP_SUB ||
                  held_op == NALU_OP_SUBTRACT_WITH_BORROW;
  wire is_arith = is_add || is_sub;
  wire is_logic = held_op == NALU_OP_AND || held_op == NALU_OP_OR ||
                  held_op == NALU_OP_XOR;
  wire is_btest = held_op == NALU_OP_SKIP_IF_BITS_SET ||
                  held_op == NALU_OP_SKIP_IF_BITS_CLEAR;
  wire is_cmp   = held_op == NALU_OP_SKIP_IF_EQUAL ||
                  held_op == NALU_OP_SKIP_IF_UNEQUAL ||
                  held_op == NALU_OP_SKIP_IF_NO_BORROW ||
                  held_op == NALU_OP_SKIP_IF_BORROW;
  wire is_rot   = held_op == NALU_OP_ROTATE_RIGHT_THROUGH_CARRY;

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // carry as extra term
  wire       use_carry = (held_op == NALU_OP_ADD_WITH_CARRY ||
                          held_op == NALU_OP_SUBTRACT_WITH_BORROW) &&
                         carry_flag;
  wire [4:0] bin_sum  = {1'b0, temp_a} + {1'b0, temp_b} +
                        {4'h0, use_carry};
  wire [4:0] bin_diff = {1'b0, temp_a} - {1'b0, temp_b} -
                        {4'h0, use_carry};
  wire [4:0] bin_raw  = is_sub ? bin_diff : bin_sum;
  wire [4:0] cmp_diff = {1'b0, temp_a} - {1'b0, temp_b};

  wire [3:0] dec_value;
  wire       dec_carry;

  // The correction always runs; the decimal flag only picks its output.
  // decimal correction path
  nalu_decimal_fix nalu_decimal_fix_inst (
    .raw_in      (bin_raw),
    .subtract_in (is_sub),
    .fixed_out   (dec_value),
    .carry_out   (dec_carry)
  );

  wire [3:0] arith_value = decimal_mode_flag ? dec_value : bin_raw[3:0];
  wire       arith_carry = decimal_mode_flag ? dec_carry : bin_raw[4];
  wire       arith_zero  = arith_value == NIB_ZERO;

  // ----------------------------------------------------------------
  // Logical, test, compare and rotate
  // ----------------------------------------------------------------
  wire [3:0] logic_value;
  wire [3:0] bit_hit;
  wire [3:0] bit_miss;

  // One slice per bit keeps the bitwise result and both mask tests together.
  for (genvar idx = 0; idx < NIB_W; idx = idx + 1) begin : g_bit
    assign logic_value[idx] =
        held_op == NALU_OP_AND ? (temp_a[idx] & temp_b[idx])
      : held_op == NALU_OP_OR  ? (temp_a[idx] | temp_b[idx])
      : (temp_a[idx] ^ temp_b[idx]);
    assign bit_hit[idx]  = !temp_b[idx] || temp_a[idx];
    assign bit_miss[idx] = !temp_b[idx] || !temp_a[idx];
  end

  wire [3:0] rot_value = {carry_flag, temp_a[3:1]};

  wire bits_set   = &bit_hit;
  wire bits_clear = &bit_miss;

  // ----------------------------------------------------------------
  // Skip decision
  // ----------------------------------------------------------------
  logic take_skip;
  always_comb begin
    case (held_op)
      NALU_OP_SKIP_IF_BITS_SET:   take_skip = bits_set;
      NALU_OP_SKIP_IF_BITS_CLEAR: take_skip = bits_clear;
      NALU_OP_SKIP_IF_EQUAL:      take_skip = cmp_diff[3:0] == NIB_ZERO;
      NALU_OP_SKIP_IF_UNEQUAL:    take_skip = cmp_diff[3:0] != NIB_ZERO;
      NALU_OP_SKIP_IF_NO_BORROW:  take_skip = !cmp_diff[4];
      NALU_OP_SKIP_IF_BORROW:     take_skip = cmp_diff[4];
      default:                    take_skip = 1'b0;
    endcase
  end

  // arithmetic store gated by compare mode
  wire do_write = is_arith ? !compare_mode_flag : (is_logic || is_rot);
  wire [3:0] value = is_arith ? arith_value
                   : is_rot   ? rot_value
                   : is_logic ? logic_value
                   : NIB_ZERO;

  // ----------------------------------------------------------------
  // Flag next values
  // ----------------------------------------------------------------
  // zero flag with compare mode clear
  // chained zero with compare mode set
  wire next_zero_alu = !is_arith ? zero_flag
                     : compare_mode_flag ? (zero_flag && arith_zero)
                     : arith_zero;
  // carry only by arithmetic and rotate
  wire next_carry_alu = is_arith ? arith_carry
                      : is_rot   ? temp_a[0]
                      : carry_flag;
  wire next_cmp_alu = is_btest ? 1'b0 : compare_mode_flag;

  // ----------------------------------------------------------------
  // Status word access
  // ----------------------------------------------------------------
  wire psw_hi_wr = sys_write_in && sys_addr_in == PSW_HIGH_ADDR;
  wire psw_lo_wr = sys_write_in && sys_addr_in == PSW_LOW_ADDR;

  // Software writes win over a same-cycle compute, so a forced flag sticks.
  // status word write overrides the ALU update
  wire next_zero  = psw_hi_wr ? sys_wdata_in[PSW_HI_ZERO_BIT]
                  : compute ? next_zero_alu : zero_flag;
  wire next_carry = psw_hi_wr ? sys_wdata_in[PSW_HI_CARRY_BIT]
                  : compute ? next_carry_alu : carry_flag;
  wire next_cmp   = psw_hi_wr ? sys_wdata_in[PSW_HI_COMPARE_BIT]
                  : compute ? next_cmp_alu : compare_mode_flag;
  wire next_dec   = psw_lo_wr ? sys_wdata_in[PSW_LO_DECIMAL_BIT]
                  : decimal_mode_flag;
  wire next_ixe   = psw_lo_wr ? sys_wdata_in[PSW_LO_INDEX_BIT]
                  : index_enable_flag;

  wire [3:0] psw_hi_view = {1'b0, compare_mode_flag, carry_flag, zero_flag};
  wire [3:0] psw_lo_view = {2'b00, decimal_mode_flag, index_enable_flag};
  wire [3:0] next_rdata  = sys_raddr_in == PSW_HIGH_ADDR ? psw_hi_view
                         : sys_raddr_in == PSW_LOW_ADDR  ? psw_lo_view
                         : NIB_ZERO;

  // skip consumed by the following instruction
  wire next_skip_pending = compute && (is_btest || is_cmp) ? take_skip
                         : next_is_instr_in ? 1'b0 : skip_pending;

  // ----------------------------------------------------------------
  // Temporary registers
  // ----------------------------------------------------------------
  // operands latched before compute
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      temp_a  <= NIB_ZERO;
      temp_b  <= NIB_ZERO;
      held_op <= NALU_OP_NONE;
    end else if (start_in) begin
      temp_a  <= first_operand_in;
      temp_b  <= second_operand_in;
      held_op <= op_in;
    end
  end

  // A start on the compute edge reloads the operands, yet that edge still
  // registers the old result, so starts may follow back to back.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      compute <= 1'b0;
    end else begin
      compute <= start_in;
    end
  end

  // ----------------------------------------------------------------
  // Status flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      zero_flag         <= 1'b0;
      carry_flag        <= 1'b0;
      compare_mode_flag <= 1'b0;
    end else begin
      zero_flag         <= next_zero;
      carry_flag        <= next_carry;
      compare_mode_flag <= next_cmp;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      decimal_mode_flag <= 1'b0;
      index_enable_flag <= 1'b0;
    end else begin
      decimal_mode_flag <= next_dec;
      index_enable_flag <= next_ixe;
    end
  end

  // A skip stays armed until the sequencer issues the next instruction.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      skip_pending <= 1'b0;
    end else begin
      skip_pending <= next_skip_pending;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is registered so the sequencer sees a clean cycle.
  // qualifiers aligned with result
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      result_out       <= NIB_ZERO;
      result_valid_out <= 1'b0;
      write_back_out   <= 1'b0;
      skip_out         <= 1'b0;
    end else begin
      result_out       <= compute ? value : result_out;
      result_valid_out <= compute;
      write_back_out   <= compute && do_write;
      skip_out         <= compute && take_skip;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      squash_out <= 1'b0;
    end else begin
      squash_out <= next_is_instr_in && skip_pending;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      index_modify_out <= 1'b0;
    end else begin
      index_modify_out <= start_in && next_ixe && op_in != NALU_OP_NONE;
    end
  end

  // Read data is registered, so it appears one cycle after the address.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sys_rdata_out <= NIB_ZERO;
    end else begin
      sys_rdata_out <= next_rdata;
    end
  end

  // Flag outputs carry the value being loaded, so they never lag the flags.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      zero_flag_out         <= 1'b0;
      carry_flag_out        <= 1'b0;
      compare_mode_flag_out <= 1'b0;
      decimal_mode_flag_out <= 1'b0;
    end else begin
      zero_flag_out         <= next_zero;
      carry_flag_out        <= next_carry;
      compare_mode_flag_out <= next_cmp;
      decimal_mode_flag_out <= next_dec;
    end
  end
endmodule : nalu_core
`default_nettype wire

// [bench/nalu_core_assertions.sv]
// Port-level assertions for the nibble ALU.
`timescale 1ns/1ns
`default_nettype none
module nalu_core_assertions (
  input wire logic               clk_in,
  input wire logic               sys_rst_in,
  input wire logic               start_in,
  input wire nalu_pkg::nalu_op_e op_in,
  input wire logic         [3:0] first_operand_in,
  input wire logic         [3:0] second_operand_in,
  input wire logic               sys_write_in,
  input wire logic         [3:0] result_out,
  input wire logic               result_valid_out,
  input wire logic               write_back_out,
  input wire logic               skip_out,
  input wire logic               zero_flag_out,
  input wire logic               carry_flag_out,
  input wire logic               compare_mode_flag_out
);
  import nalu_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  valid_latency_a: assert property (
    start_in |-> ##2 result_valid_out) else $error("Result missing.");
  qualifier_align_a: assert property (
    write_back_out || skip_out |-> result_valid_out) else $error("Stray flag.");
  logic_store_a: assert property (
    start_in && op_in inside {NALU_OP_AND, NALU_OP_OR, NALU_OP_XOR}
    |-> ##2 write_back_out && !skip_out) else $error("Logic not stored.");
  compare_no_store_a: assert property (
    start_in && op_in inside {NALU_OP_SKIP_IF_EQUAL, NALU_OP_SKIP_IF_BORROW,
    NALU_OP_SKIP_IF_UNEQUAL, NALU_OP_SKIP_IF_NO_BORROW}
    |-> ##2 !write_back_out) else $error("Compare stored.");
  equal_skip_a: assert property (
    start_in && op_in == NALU_OP_SKIP_IF_EQUAL |-> ##2 skip_out ==
    ($past(first_operand_in, 2) == $past(second_operand_in, 2)))
    else $error("Equal skip wrong.");
  test_clears_cmp_a: assert property (
    start_in && op_in inside {NALU_OP_SKIP_IF_BITS_SET,
    NALU_OP_SKIP_IF_BITS_CLEAR} ##1 !sys_write_in |=> !compare_mode_flag_out)
    else $error("Compare mode kept.");
  logic_keeps_flags_a: assert property (
    start_in && op_in inside {NALU_OP_AND, NALU_OP_OR, NALU_OP_XOR}
    ##1 !sys_write_in |=> $stable(zero_flag_out) && $stable(carry_flag_out))
    else $error("Logic moved flags.");
  rotate_through_a: assert property (
    start_in && op_in == NALU_OP_ROTATE_RIGHT_THROUGH_CARRY ##1 !sys_write_in
    |=> result_out == (($past(first_operand_in, 2) >> 1) |
    {$past(carry_flag_out), 3'h0}) &&
    carry_flag_out == ^($past(first_operand_in, 2) & 4'h1))
    else $error("Rotate wrong.");
endmodule : nalu_core_assertions
bind nalu_core nalu_core_assertions nalu_core_assertions_inst (.clk_in,
  .sys_rst_in, .start_in, .op_in, .first_operand_in, .second_operand_in,
  .sys_write_in, .result_out, .result_valid_out, .write_back_out, .skip_out,
  .zero_flag_out, .carry_flag_out, .compare_mode_flag_out);
`default_nettype wire

// [bench/nalu_seq_model.sv]
// Sequencer model that issues ALU operations.
`timescale 1ns/1ns
`default_nettype none
module nalu_seq_model (
  input  wire logic              clk_in,
  output logic                   start_out,
  output var nalu_pkg::nalu_op_e op_out,
  output logic             [3:0] first_out,
  output logic             [3:0] second_out,
  output logic                   next_out
);
  import nalu_pkg::*;
  initial begin
    start_out = 1'b0;
    op_out = NALU_OP_NONE;
    next_out = 1'b0;
  end
  // Released operand lines flip, so a late read cannot pass by luck.
  task automatic issue(input nalu_op_e o, input logic [3:0] a, b);
    @(negedge clk_in);
    start_out = 1'b1;
    op_out = o;
    first_out = a;
    second_out = b;
    @(negedge clk_in);
    start_out = 1'b0;
    op_out = NALU_OP_NONE;
    first_out = ~a;
    second_out = ~b;
  endtask : issue
  task automatic next_instr();
    @(negedge clk_in);
    next_out = 1'b1;
    @(negedge clk_in);
    next_out = 1'b0;
  endtask : next_instr
endmodule : nalu_seq_model
`default_nettype wire

// [bench/nibble_alu_with_status_flags_tb.sv]
// Self-checking bench for the nibble ALU.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module nibble_alu_with_status_flags_tb;
  import nalu_pkg::*;
  logic       clk_in = 1'b0, sys_rst_in = 1'b1, sys_write_in = 1'b0;
  logic [6:0] sys_addr_in = 7'h00, sys_raddr_in = 7'h00;
  logic [3:0] sys_wdata_in = 4'h0, first_operand_in, second_operand_in;
  logic [3:0] sys_rdata_out, result_out;
  logic       start_in, next_is_instr_in, result_valid_out, write_back_out;
  logic       skip_out, squash_out, index_modify_out, zero_flag_out;
  logic       carry_flag_out, compare_mode_flag_out, decimal_mode_flag_out;
  nalu_op_e   op_in;
  int         miscompares = 0, checks = 0, cycles = 0;
  nalu_op_e   ix_ops [5] = '{NALU_OP_ADD, NALU_OP_AND, NALU_OP_SKIP_IF_EQUAL,
    NALU_OP_SKIP_IF_BITS_SET, NALU_OP_ROTATE_RIGHT_THROUGH_CARRY};
  nalu_core nalu_core_inst (.clk_in, .sys_rst_in, .start_in, .op_in,
    .first_operand_in, .second_operand_in, .next_is_instr_in, .sys_write_in,
    .sys_addr_in, .sys_wdata_in, .sys_raddr_in, .sys_rdata_out, .result_out,
    .result_valid_out, .write_back_out, .skip_out, .squash_out,
    .index_modify_out, .zero_flag_out, .carry_flag_out,
    .compare_mode_flag_out, .decimal_mode_flag_out);
  nalu_seq_model nalu_seq_model_inst (.clk_in, .start_out(start_in),
    .op_out(op_in), .first_out(first_operand_in),
    .second_out(second_operand_in), .next_out(next_is_instr_in));
  initial forever #5 clk_in = ~clk_in;
  // The full run needs under two hundred cycles; the ceiling leaves margin.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    @(negedge clk_in);
    sys_write_in = 1'b1;
    sys_addr_in = a;
    sys_wdata_in = d;
    @(negedge clk_in);
    sys_write_in = 1'b0;
    sys_wdata_in = ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [3:0] e);
    @(negedge clk_in);
    sys_raddr_in = a;
    @(negedge clk_in);
    `CHK(sys_rdata_out, e)
  endtask : rd
  // Flags f are write-back, skip, zero and carry, high bit first.
  task automatic run(input nalu_op_e o, input logic [3:0] a, b, r, f);
    nalu_seq_model_inst.issue(o, a, b);
    @(negedge clk_in);
    `CHK(result_valid_out, 1'b1)
    `CHK({write_back_out, skip_out, zero_flag_out, carry_flag_out}, f)
    if (f[3])
      `CHK(result_out, r)
  endtask : run
  initial begin
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    `CHK(zero_flag_out | carry_flag_out, 1'b0)
    rd(PSW_HIGH_ADDR, 4'h0);
    wr(PSW_LOW_ADDR, 4'hF);
    rd(PSW_LOW_ADDR, 4'h3);
    wr(PSW_HIGH_ADDR, 4'hF);
    `CHK(compare_mode_flag_out & decimal_mode_flag_out, 1'b1)
    rd(PSW_HIGH_ADDR, 4'h7);
    rd(7'h10, 4'h0);
    wr(PSW_LOW_ADDR, 4'h0);
    wr(PSW_HIGH_ADDR, 4'h0);
    run(NALU_OP_ADD, 4'hF, 4'h1, 4'h0, 4'hB);
    run(NALU_OP_ADD_WITH_CARRY, 4'h8, 4'h0, 4'h9, 4'h8);
    run(NALU_OP_SUB, 4'h3, 4'h5, 4'hE, 4'h9);
    run(NALU_OP_SUBTRACT_WITH_BORROW, 4'h5, 4'h2, 4'h2, 4'h8);
    run(NALU_OP_SUB, 4'h0, 4'h1, 4'hF, 4'h9);
    run(NALU_OP_AND, 4'hC, 4'hA, 4'h8, 4'h9);
    run(NALU_OP_OR, 4'hC, 4'hA, 4'hE, 4'h9);
    run(NALU_OP_XOR, 4'hC, 4'hA, 4'h6, 4'h9);
    wr(PSW_HIGH_ADDR, 4'h6);
    run(NALU_OP_SKIP_IF_BITS_SET, 4'hB, 4'h3, 4'h0, 4'h5);
    `CHK(compare_mode_flag_out, 1'b0)
    wr(PSW_HIGH_ADDR, 4'h4);
    run(NALU_OP_SKIP_IF_BITS_CLEAR, 4'hB, 4'h4, 4'h0, 4'h4);
    `CHK(compare_mode_flag_out, 1'b0)
    run(NALU_OP_SKIP_IF_BITS_CLEAR, 4'hB, 4'h1, 4'h0, 4'h0);
    wr(PSW_HIGH_ADDR, 4'h4);
    run(NALU_OP_SKIP_IF_EQUAL, 4'h5, 4'h5, 4'h0, 4'h4);
    run(NALU_OP_SKIP_IF_EQUAL, 4'h5, 4'h6, 4'h0, 4'h0);
    run(NALU_OP_SKIP_IF_UNEQUAL, 4'h5, 4'h6, 4'h0, 4'h4);
    run(NALU_OP_SKIP_IF_NO_BORROW, 4'h5, 4'h5, 4'h0, 4'h4);
    run(NALU_OP_SKIP_IF_BORROW, 4'h3, 4'h5, 4'h0, 4'h4);
    `CHK(compare_mode_flag_out, 1'b1)
    wr(PSW_HIGH_ADDR, 4'h5);
    run(NALU_OP_ADD, 4'h2, 4'hE, 4'h0, 4'h3);
    run(NALU_OP_ADD, 4'h1, 4'h1, 4'h2, 4'h0);
    run(NALU_OP_SUB, 4'h4, 4'h4, 4'h0, 4'h0);
    wr(PSW_HIGH_ADDR, 4'h2);
    run(NALU_OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h4, 4'h0, 4'hA, 4'h8);
    run(NALU_OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h1, 4'h0, 4'h0, 4'h9);
    wr(PSW_LOW_ADDR, 4'h2);
    wr(PSW_HIGH_ADDR, 4'h0);
    run(NALU_OP_ADD, 4'h7, 4'h5, 4'h2, 4'h9);
    run(NALU_OP_ADD, 4'h9, 4'h9, 4'h8, 4'h9);
    run(NALU_OP_ADD, 4'hF, 4'h6, 4'hF, 4'h9);
    run(NALU_OP_ADD, 4'hF, 4'hD, 4'hA, 4'h9);
    run(NALU_OP_SUB, 4'hC, 4'h0, 4'hE, 4'h9);
    run(NALU_OP_SUB, 4'h0, 4'hF, 4'hF, 4'h9);
    run(NALU_OP_SUB, 4'h3, 4'h4, 4'h9, 4'h9);
    run(NALU_OP_OR, 4'h9, 4'h6, 4'hF, 4'h9);
    wr(PSW_LOW_ADDR, 4'h1);
    foreach (ix_ops[i]) begin
      nalu_seq_model_inst.issue(ix_ops[i], 4'h3, 4'h1);
      `CHK(index_modify_out, 1'b1)
      @(negedge clk_in);
    end
    wr(PSW_LOW_ADDR, 4'h0);
    nalu_seq_model_inst.issue(NALU_OP_AND, 4'h3, 4'h1);
    `CHK(index_modify_out, 1'b0)
    run(NALU_OP_SKIP_IF_EQUAL, 4'h7, 4'h7, 4'h0, 4'h5);
    nalu_seq_model_inst.next_instr();
    `CHK(squash_out, 1'b1)
    nalu_seq_model_inst.next_instr();
    `CHK(squash_out, 1'b0)
    wrap_up();
  end
endmodule : nibble_alu_with_status_flags_tb
`default_nettype wire
